// >>> rtl/call_clear_compare_exec.sv
`timescale 1ns/1ps

// Overview of operation
// RULE_01: subroutine jump pushes pc plus 4, loads 20-bit literal into pc 20:1.
// RULE_02: shadow bit 1 copies accumulator, flags, bank select into shadows.
// RULE_03: first word holds shadow bit and literal 7:0, second literal 19:8.
// RULE_04: clear-file writes zero to register, sets zero flag, one cycle.
// RULE_05: access bit 0 uses access bank, 1 uses bank select register.
// RULE_06: watchdog kick clears counter and postscaler, sets timeout and powerdown.
// RULE_07: complement-file writes inverse, updates only negative and zero flags.
// RULE_08: compares are unsigned and change no operand or flag.
// RULE_09: equal compare skips next instruction when register equals accumulator.
// RULE_10: a taken skip discards the fetched instruction as an idle cycle.
// RULE_11: compare takes one, two, or three cycles over a two-word instruction.
// RULE_12: equal compare opcode prefix is 0110 001a plus file address.
// RULE_13: greater compare opcode 0110 010a skips when register exceeds accumulator.
// RULE_14: complement destination bit 0 goes to accumulator, 1 to register.
// RULE_15: second jump cycle is idle; push and pc load come from first. The code issues push, pc load and discard together, from the ST_CALL2 cycle.
module call_clear_compare_exec
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [20:0] pc,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output file_wr_t file_wr,
    output flow_t flow,
    output logic wdt_clear,
    output logic discard
);

    // ==========================================================
    // reset release
    logic rst_meta_q, rst_n_q;

    // async assert, two-flop release so every flop leaves reset together
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // helpers
    function automatic logic is_two_word(input logic [15:0] w);
        is_two_word = (w[15:9] == OP_CALL) || (w[15:8] == OP_GOTO) || (w[15:12] == OP_MOVE2);
    endfunction : is_two_word

    function automatic logic [11:0] file_address(input logic [15:0] w, input logic [3:0] bank);
        logic [3:0] b;
        b = bank;
        if (!w[BIT_ACCESS]) // RULE_05
        begin
            b = (w[7:0] < ACCESS_SPLIT) ? RST_BANK : ACCESS_HIGH_BANK;
        end
        file_address = {b, w[7:0]};
    endfunction : file_address

    // ==========================================================
    // state
    exec_state_t state_q, state_d;
    logic [7:0] accum_q, accum_d, flags_q, flags_d;
    logic [3:0] bank_q, bank_d;
    logic [7:0] sh_accum_q, sh_accum_d, sh_flags_q, sh_flags_d;
    logic [3:0] sh_bank_q, sh_bank_d;
    logic [1:0] pwr_q, pwr_d;
    logic [7:0] lit_lo_q, lit_lo_d;
    logic [20:0] call_pc_q, call_pc_d;
    logic [7:0] rdata_q, rdata_d;
    file_wr_t fw_q, fw_d;
    flow_t flow_q, flow_d;
    logic kick_q, kick_d, disc_q, disc_d;
    logic [7:0] inv;

    // next-state: bus writes first, then the executing instruction overrides
    always_comb
    begin
        state_d = state_q;
        accum_d = accum_q;
        flags_d = flags_q;
        bank_d = bank_q;
        sh_accum_d = sh_accum_q;
        sh_flags_d = sh_flags_q;
        sh_bank_d = sh_bank_q;
        pwr_d = pwr_q;
        lit_lo_d = lit_lo_q;
        call_pc_d = call_pc_q;
        fw_d = '0;
        flow_d = '0;
        kick_d = 1'b0;
        disc_d = 1'b0;
        inv = ~file_rdata;
        rdata_d = RST_BYTE;
        if (bus_wr)
        begin
            case (bus_addr)
                ADDR_ACCUM: accum_d = bus_wdata;
                ADDR_FLAGS: flags_d = bus_wdata;
                ADDR_BANK: bank_d = bus_wdata[3:0];
                ADDR_PWR: pwr_d = bus_wdata[1:0];
                default: ;
            endcase
        end
        if (bus_rd)
        begin
            case (bus_addr)
                ADDR_ACCUM: rdata_d = accum_q;
                ADDR_FLAGS: rdata_d = flags_q;
                ADDR_BANK: rdata_d = {4'h0, bank_q};
                ADDR_SH_ACCUM: rdata_d = sh_accum_q;
                ADDR_SH_FLAGS: rdata_d = sh_flags_q;
                ADDR_SH_BANK: rdata_d = {4'h0, sh_bank_q};
                ADDR_PWR: rdata_d = {6'h00, pwr_q};
                default: rdata_d = RST_BYTE;
            endcase
        end
        if (instr_valid)
        begin
            case (state_q)
                ST_EXEC:
                begin
                    if (instr[15:9] == OP_CALL)
                    begin
                        lit_lo_d = instr[7:0]; // RULE_03
                        call_pc_d = pc;
                        state_d = ST_CALL2;
                        if (instr[BIT_SHADOW]) // RULE_02
                        begin
                            sh_accum_d = accum_q;
                            sh_flags_d = flags_q;
                            sh_bank_d = bank_q;
                        end
                    end
                    else if (instr[15:9] == OP_ZERO)
                    begin
                        fw_d = '{1'b1, file_address(instr, bank_q), RST_BYTE}; // RULE_04
                        flags_d[FLAG_Z] = 1'b1; // RULE_04
                    end
                    else if (instr == OP_KICK)
                    begin
                        kick_d = 1'b1; // RULE_06
                        pwr_d = RST_PWR; // RULE_06
                    end
                    else if (instr[15:10] == OP_INV)
                    begin
                        if (instr[BIT_DEST]) // RULE_14
                        begin
                            fw_d = '{1'b1, file_address(instr, bank_q), inv}; // RULE_07
                        end
                        else
                        begin
                            accum_d = inv; // RULE_14
                        end
                        flags_d[FLAG_N] = inv[7]; // RULE_07
                        flags_d[FLAG_Z] = (inv == RST_BYTE); // RULE_07
                    end
                    else if (instr[15:9] == OP_CMPEQ) // RULE_12
                    begin
                        if (file_rdata == accum_q) // RULE_09
                        begin
                            state_d = ST_SKIP; // RULE_09
                        end
                    end
                    else if (instr[15:9] == OP_CMPGT) // RULE_13
                    begin
                        if (file_rdata > accum_q) // RULE_13
                        begin
                            state_d = ST_SKIP;
                        end
                    end
                end
                ST_CALL2:
                begin
                    // second word carries literal 19:8; execute the jump now
                    flow_d.push = 1'b1; // RULE_01
                    flow_d.ret_addr = call_pc_q + RET_OFFSET; // RULE_01
                    flow_d.load = 1'b1; // RULE_15
                    flow_d.target = {instr[11:0], lit_lo_q, 1'b0}; // RULE_03
                    disc_d = 1'b1; // RULE_15
                    state_d = ST_EXEC;
                end
                ST_SKIP:
                begin
                    disc_d = 1'b1; // RULE_10
                    state_d = is_two_word(instr) ? ST_SKIP2 : ST_EXEC; // RULE_11
                end
                ST_SKIP2:
                begin
                    disc_d = 1'b1; // RULE_11
                    state_d = ST_EXEC;
                end
                default: state_d = ST_EXEC;
            endcase
        end
    end

    // registers only
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= ST_EXEC;
            accum_q <= RST_BYTE;
            flags_q <= RST_BYTE;
            bank_q <= RST_BANK;
            sh_accum_q <= RST_BYTE;
            sh_flags_q <= RST_BYTE;
            sh_bank_q <= RST_BANK;
            pwr_q <= RST_PWR;
            lit_lo_q <= RST_BYTE;
            call_pc_q <= '0;
            rdata_q <= RST_BYTE;
            fw_q <= '0;
            flow_q <= '0;
            kick_q <= 1'b0;
            disc_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            accum_q <= accum_d;
            flags_q <= flags_d;
            bank_q <= bank_d;
            sh_accum_q <= sh_accum_d;
            sh_flags_q <= sh_flags_d;
            sh_bank_q <= sh_bank_d;
            pwr_q <= pwr_d;
            lit_lo_q <= lit_lo_d;
            call_pc_q <= call_pc_d;
            rdata_q <= rdata_d;
            fw_q <= fw_d;
            flow_q <= flow_d;
            kick_q <= kick_d;
            disc_q <= disc_d;
        end
    end

    assign bus_rdata = rdata_q;
    assign file_wr = fw_q;
    assign flow = flow_q;
    assign wdt_clear = kick_q;
    assign discard = disc_q;

    // ==========================================================
    // checks
    logic exec_now;
    assign exec_now = instr_valid && (state_q == ST_EXEC) && !bus_wr;

    property p_call_push;
        @(posedge clk) disable iff (!rst_n_q)
        (instr_valid && state_q == ST_CALL2) |=> (flow_q.push && flow_q.ret_addr == $past(call_pc_q) + 21'h000004);
    endproperty
    a_call_push: assert property (p_call_push) else $error("return address not pc plus 4"); // RULE_01

    property p_shadow;
        @(posedge clk) disable iff (!rst_n_q)
        (exec_now && instr[15:9] == OP_CALL && instr[BIT_SHADOW]) |=> (sh_accum_q == $past(accum_q)
            && sh_bank_q == $past(bank_q));
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow copy missing"); // RULE_02

    property p_target;
        @(posedge clk) disable iff (!rst_n_q)
        (instr_valid && state_q == ST_CALL2) |=> (flow_q.target[20:9] == $past(instr[11:0])
            && flow_q.target[8:1] == $past(lit_lo_q) && !flow_q.target[0]);
    endproperty
    a_target: assert property (p_target) else $error("jump target misassembled"); // RULE_03

    property p_zero;
        @(posedge clk) disable iff (!rst_n_q)
        (exec_now && instr[15:9] == OP_ZERO) |=> (fw_q.we && fw_q.data == 8'h00 && flags_q[FLAG_Z]);
    endproperty
    a_zero: assert property (p_zero) else $error("clear-file failed"); // RULE_04

    property p_access;
        @(posedge clk) disable iff (!rst_n_q)
        (exec_now && instr[15:9] == OP_ZERO && instr[BIT_ACCESS]) |=> (fw_q.addr[11:8] == $past(bank_q));
    endproperty
    a_access: assert property (p_access) else $error("bank select ignored"); // RULE_05

    property p_kick;
        @(posedge clk) disable iff (!rst_n_q)
        (exec_now && instr == OP_KICK) |=> (wdt_clear && pwr_q == 2'h3)
            ##1 (!wdt_clear || $past(exec_now && instr == OP_KICK));
    endproperty
    a_kick: assert property (p_kick) else $error("watchdog kick wrong"); // RULE_06

    property p_inv_acc;
        @(posedge clk) disable iff (!rst_n_q)
        (exec_now && instr[15:10] == OP_INV && !instr[BIT_DEST]) |=> (accum_q == ~$past(file_rdata)
            && !fw_q.we);
    endproperty
    a_inv_acc: assert property (p_inv_acc) else $error("complement to accumulator wrong"); // RULE_14

    property p_cmp_flags;
        @(posedge clk) disable iff (!rst_n_q)
        (exec_now && (instr[15:9] == OP_CMPEQ || instr[15:9] == OP_CMPGT)) |=> (flags_q == $past(flags_q)
            && accum_q == $past(accum_q) && !fw_q.we);
    endproperty
    a_cmp_flags: assert property (p_cmp_flags) else $error("compare changed state"); // RULE_08

    property p_eq_skip;
        @(posedge clk) disable iff (!rst_n_q)
        (exec_now && instr[15:9] == OP_CMPEQ && file_rdata == accum_q) ##1 instr_valid |=> discard;
    endproperty
    a_eq_skip: assert property (p_eq_skip) else $error("equal skip missed"); // RULE_09

    property p_gt_noskip;
        @(posedge clk) disable iff (!rst_n_q)
        (exec_now && instr[15:9] == OP_CMPGT && file_rdata <= accum_q) |=> state_q == ST_EXEC;
    endproperty
    a_gt_noskip: assert property (p_gt_noskip) else $error("greater skip taken wrongly"); // RULE_13

    property p_skip2;
        @(posedge clk) disable iff (!rst_n_q)
        (instr_valid && state_q == ST_SKIP && is_two_word(instr)) ##1 instr_valid |-> discard [*2];
    endproperty
    a_skip2: assert property (p_skip2) else $error("two-word skip not three cycles"); // RULE_11

endmodule : call_clear_compare_exec

// >>> rtl/exec_pkg.sv
package exec_pkg;

    // ==========================================================
    // opcode patterns (upper bits of the first instruction word)
    localparam logic [6:0] OP_CALL = 7'h76;     // 1110 110s
    localparam logic [6:0] OP_ZERO = 7'h35;     // 0110 101a
    localparam logic [6:0] OP_CMPEQ = 7'h31;    // 0110 001a
    localparam logic [6:0] OP_CMPGT = 7'h32;    // 0110 010a
    localparam logic [5:0] OP_INV = 6'h07;      // 0001 11da
    localparam logic [15:0] OP_KICK = 16'h0004; // 0000 0000 0000 0100
    localparam logic [7:0] OP_GOTO = 8'hef;     // other two-word first word
    localparam logic [3:0] OP_MOVE2 = 4'hc;     // other two-word first word

    // ==========================================================
    // field positions inside a word
    localparam int BIT_SHADOW = 8;
    localparam int BIT_ACCESS = 8;
    localparam int BIT_DEST = 9;

    // ==========================================================
    // flag positions and access bank split
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 4;
    localparam int PWR_TIMEOUT = 1;
    localparam int PWR_DOWN = 0;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [20:0] RET_OFFSET = 21'h000004;

    // ==========================================================
    // register map of the plain port (byte addresses)
    localparam logic [7:0] ADDR_ACCUM = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_BANK = 8'h08;
    localparam logic [7:0] ADDR_SH_ACCUM = 8'h0c;
    localparam logic [7:0] ADDR_SH_FLAGS = 8'h10;
    localparam logic [7:0] ADDR_SH_BANK = 8'h14;
    localparam logic [7:0] ADDR_PWR = 8'h18;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [1:0] RST_PWR = 2'h3;

    typedef enum {ST_EXEC, ST_CALL2, ST_SKIP, ST_SKIP2} exec_state_t;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] data;
    } file_wr_t;

    typedef struct packed {
        logic push;
        logic [20:0] ret_addr;
        logic load;
        logic [20:0] target;
    } flow_t;

endpackage : exec_pkg

// >>> verif/call_clear_compare_exec_tb.sv
`timescale 1ns/1ps

module call_clear_compare_exec_tb
    import exec_pkg::*;
;
    logic clk;
    logic nrst;
    logic instr_valid;
    logic [15:0] instr;
    logic [20:0] pc;
    logic [7:0] file_rdata;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] bus_rdata;
    file_wr_t file_wr;
    flow_t flow;
    logic wdt_clear;
    logic discard;
    int mismatches;
    int checks;
    int seed;
    int i;
    logic [31:0] r;
    logic [31:0] r2;
    logic [7:0] acc, flg, rd, f, res, sh_acc, sh_flg, sh_bnk;
    logic [3:0] bnk;
    logic [19:0] k;
    logic [20:0] pcv;
    logic a, d, s, tw, skip;

    call_clear_compare_exec u_call_clear_compare_exec (
        .clk(clk),
        .nrst(nrst),
        .instr_valid(instr_valid),
        .instr(instr),
        .pc(pc),
        .file_rdata(file_rdata),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata),
        .file_wr(file_wr),
        .flow(flow),
        .wdt_clear(wdt_clear),
        .discard(discard)
    );

    // ==========================================================
    // clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // a hang counts as a failure, not a silent stop
    initial
    begin
        #4000000;
        mismatches++;
        report_and_stop();
    end

    // ==========================================================
    // helpers
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // one instruction word per cycle; the word driven here is taken at the next edge, so its outputs are settled after the #1 of the following step
    task automatic step(input logic v, input logic [15:0] w, input logic [7:0] rdv);
        @(posedge clk);
        instr_valid <= v;
        instr <= w;
        file_rdata <= rdv;
        pc <= pcv;
        #1;
    endtask : step

    task automatic bus_write(input logic [7:0] adr, input logic [7:0] dat);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= adr;
        bus_wdata <= dat;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    // read data stand only in the cycle after the strobe, so sample there
    task automatic bus_read(input logic [7:0] adr, output logic [7:0] dat);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= adr;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        dat = bus_rdata;
    endtask : bus_read

    function automatic logic [11:0] faddr(input logic ab, input logic [7:0] fa, input logic [3:0] b);
        if (ab)
            return {b, fa};
        return (fa < ACCESS_SPLIT) ? {4'h0, fa} : {ACCESS_HIGH_BANK, fa};
    endfunction : faddr

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // main sequence
    initial
    begin
        seed = 32'h2768aa82;
        mismatches = 0;
        checks = 0;
        nrst = 1'b0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        pc = 21'h000000;
        pcv = 21'h000000;
        file_rdata = 8'h00;
        bus_addr = 8'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        sh_acc = 8'h00;
        sh_flg = 8'h00;
        sh_bnk = 8'h00;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        // reset values, including the unmapped slot after power status
        for (i = 0; i < 8; i++)
        begin
            bus_read(8'(i * 4), rd);
            check(rd, (8'(i * 4) == ADDR_PWR) ? {6'h00, RST_PWR} : RST_BYTE);
        end
        // every op kind in turn, operands random; boundary file addresses 7f/80 and equal operands forced often
        for (i = 0; i < 60; i++)
        begin
            r = $random(seed);
            r2 = $random(seed);
            acc = r[7:0];
            flg = {3'h0, r[12:8]};
            bnk = r[16:13];
            a = r[17];
            d = r[18];
            s = r[19];
            tw = r[20];
            f = r[21] ? (r[22] ? 8'h7f : 8'h80) : r[31:24];
            rd = r[23] ? acc : r2[7:0];
            k = r2[27:8];
            pcv = r2[30:10];
            bus_write(ADDR_ACCUM, acc);
            bus_write(ADDR_FLAGS, flg);
            bus_write(ADDR_BANK, {4'h0, bnk});
            case (i % 6)
                0:
                begin
                    step(1'b1, {OP_ZERO, a, f}, rd);
                    step(1'b0, 16'h0000, 8'h00);
                    check(file_wr, {1'b1, faddr(a, f, bnk), 8'h00});
                    flg[FLAG_Z] = 1'b1;
                end
                1:
                begin
                    res = ~rd;
                    step(1'b1, {OP_INV, d, a, f}, rd);
                    step(1'b0, 16'h0000, 8'h00);
                    check(file_wr, d ? {1'b1, faddr(a, f, bnk), res} : 21'h000000);
                    if (!d)
                        acc = res;
                    flg[FLAG_N] = res[7];
                    flg[FLAG_Z] = (res == 8'h00);
                end
                2, 3:
                begin
                    skip = (i % 6 == 2) ? (rd == acc) : (rd > acc);
                    step(1'b1, {(i % 6 == 2) ? OP_CMPEQ : OP_CMPGT, a, f}, rd);
                    step(1'b1, tw ? {OP_GOTO, 8'h00} : {OP_ZERO, 1'b0, 8'h10}, 8'h00);
                    check(file_wr.we, 1'b0);
                    if (tw)
                    begin
                        step(1'b1, 16'hf123, 8'h00);
                        check(discard, skip);
                    end
                    step(1'b0, 16'h0000, 8'h00);
                    // a non-skipped two-word follower may idle its second cycle, so leave it open
                    if (skip || !tw)
                        check(discard, skip);
                    if (!tw)
                    begin
                        check(file_wr.we, !skip);
                        flg[FLAG_Z] = flg[FLAG_Z] | !skip;
                    end
                end
                4:
                begin
                    step(1'b1, {OP_CALL, s, k[7:0]}, 8'h00);
                    step(1'b1, {4'hf, k[19:8]}, 8'h00);
                    step(1'b0, 16'h0000, 8'h00);
                    check(flow, {1'b1, pcv + RET_OFFSET, 1'b1, k, 1'b0});
                    check(discard, 1'b1);
                    if (s)
                    begin
                        sh_acc = acc;
                        sh_flg = flg;
                        sh_bnk = {4'h0, bnk};
                    end
                    bus_read(ADDR_SH_ACCUM, rd);
                    check(rd, sh_acc);
                    bus_read(ADDR_SH_FLAGS, rd);
                    check(rd, sh_flg);
                    bus_read(ADDR_SH_BANK, rd);
                    check(rd, sh_bnk);
                end
                default:
                begin
                    bus_write(ADDR_PWR, 8'h00);
                    step(1'b1, OP_KICK, 8'h00);
                    step(1'b0, 16'h0000, 8'h00);
                    check(wdt_clear, 1'b1);
                    step(1'b0, 16'h0000, 8'h00);
                    check(wdt_clear, 1'b0);
                    bus_read(ADDR_PWR, rd);
                    check(rd, 8'h03);
                end
            endcase
            // operands and untouched flag bits must survive every kind
            bus_read(ADDR_ACCUM, rd);
            check(rd, acc);
            bus_read(ADDR_FLAGS, rd);
            check(rd, flg);
        end
        report_and_stop();
    end

endmodule : call_clear_compare_exec_tb
